// ### logic/bad_fault_capture.sv
// Fault register loaded on the trailing edge of the shared busy line
`timescale 1ns/1ns
`default_nettype none
module bad_fault_capture (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        busyIn,
  input  wire logic        busyOwn,
  input  wire logic        memIoIn,
  input  wire logic        protect_fault_n,
  input  wire logic        ext_address_fault_n,
  input  wire logic [15:0] clearMask,
  output logic      [15:0] faultReg
);

  logic        busyPrev_q;
  logic        ownPrev_q;
  logic        memPrev_q;
  logic [15:0] setMask;
  logic        busyRise;

  // Attribution uses the owner and cycle kind seen while busy was still low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busyPrev_q <= 1'b1;
      ownPrev_q  <= 1'b0;
      memPrev_q  <= 1'b1;
    end else begin
      busyPrev_q <= busyIn;
      ownPrev_q  <= busyOwn;
      memPrev_q  <= memIoIn;
    end
  end

  assign busyRise = !busyPrev_q && busyIn;

  always_comb begin
    setMask = 16'h0000;
    if (busyRise && !protect_fault_n) begin
      setMask[bad_pkg::FLT_PROT_CPU] = ownPrev_q;
      setMask[bad_pkg::FLT_PROT_EXT] = !ownPrev_q;
    end
    if (busyRise && !ext_address_fault_n) begin
      setMask[bad_pkg::FLT_ADDR_MEM] = memPrev_q;
      setMask[bad_pkg::FLT_ADDR_IO]  = !memPrev_q;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      faultReg <= bad_pkg::FAULT_RESET;
    end else begin
      faultReg <= (faultReg & ~clearMask) | setMask;
    end
  end

  property p_prot_cpu;
    @(posedge clk) disable iff (!rst_n)
      (!busyPrev_q && busyIn && ownPrev_q && !protect_fault_n) |=> faultReg[0];
  endproperty
  a_prot_cpu: assert property (p_prot_cpu) else $error("protect fault of own cycle lost");

  property p_prot_ext;
    @(posedge clk) disable iff (!rst_n)
      (!busyPrev_q && busyIn && !ownPrev_q && !protect_fault_n) |=> faultReg[1] && !$past(busyOwn);
  endproperty
  a_prot_ext: assert property (p_prot_ext) else $error("foreign cycle fault not latched");

endmodule
`default_nettype wire

// ### logic/bad_pkg.sv
// Constants and types shared by the bus-arbitration and discrete-control block
package bad_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TRIG_PULSE_NS  = 100;
  localparam int unsigned TRIG_CYCLES_RAW = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_CYCLES    = (TRIG_CYCLES_RAW < 1) ? 1 : TRIG_CYCLES_RAW;
  localparam logic [3:0]  TRIG_CNT_LOAD  = 4'(TRIG_CYCLES);

  // I/O address whose access fires the trigger pulse
  localparam logic [15:0] TRIG_IO_ADDR   = 16'h400b;

  // APB register map (byte addresses)
  localparam logic [7:0]  REG_CMD_STATUS = 8'h00;
  localparam logic [7:0]  REG_FAULT      = 8'h04;

  // Command register write bits
  localparam int unsigned CMD_DA_ON      = 0;
  localparam int unsigned CMD_DA_OFF     = 1;
  localparam int unsigned CMD_CLR_PASS   = 2;
  localparam int unsigned CMD_TRIGGER    = 3;

  // Status read bits
  localparam int unsigned STS_DA         = 0;
  localparam int unsigned STS_PASS       = 1;
  localparam int unsigned STS_LOCK       = 2;
  localparam int unsigned STS_STATE_LSB  = 4;

  // Fault register bit positions
  localparam int unsigned FLT_PROT_CPU   = 0;
  localparam int unsigned FLT_PROT_EXT   = 1;
  localparam int unsigned FLT_ADDR_MEM   = 5;
  localparam int unsigned FLT_ADDR_IO    = 8;
  localparam logic [15:0] FAULT_RESET    = 16'h0000;

  // Instruction class of the current bus cycle
  typedef enum logic [3:0] {
    OP_NONE             = 4'h0,
    op_increment_memory = 4'h1,
    op_decrement_memory = 4'h2,
    op_set_bit          = 4'h3,
    op_reset_bit        = 4'h4,
    op_test_set_bit     = 4'h5,
    op_store_masked     = 4'h6,
    op_store_upper_byte = 4'h7,
    op_store_lower_byte = 4'h8
  } bad_op_t;

  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_END  = 3'b100
  } bad_state_t;

endpackage

// ### logic/bad_top.sv
// Bus request, busy and lock sequencing plus discrete outputs, with APB registers
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Drive bus request low when needing bus
// - Release bus request once cycle has begun
// - Start cycle after grant on idle bus
// - Bus-side outputs high impedance outside own cycles
// - Busy low at cycle start, high at end
// - Capture faults on busy rising edge
// - Busy undriven during foreign cycles
// - Latch foreign-cycle faults from monitored busy
// - Lock holds bus; others wait while held
// - Unlocked cycles: lock mimics busy
// - Listed read-modify-write instructions lock bus
// - Direct access enable: reset clear, on/off commands
// - Self-test pass set on success, command clears
// - Instruction start high cycle before instruction
// - Trigger pulses low on I/O address 400B
// - Trigger pulses once during initialization
// - Protect fault: bit 0 own, 1 foreign
// - Address fault: bit 5 memory, 8 I/O
module bad_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core-side cycle request
  input  wire logic        cycReq,
  input  wire logic        cycWrite,
  input  wire logic        cycMem,
  input  wire logic        cycData,
  input  wire logic [15:0] cycAddr,
  input  wire logic [15:0] cycWdata,
  input  wire logic [3:0]  cycOp,
  input  wire logic        cycLast,
  output logic             cycAck,
  output logic      [15:0] cycRdata,
  // Core-side discretes
  input  wire logic        instrNext,
  input  wire logic        selftestOk,
  output logic             selftest_pass,
  output logic             instr_begin,
  output logic             directAccessEn,
  output logic             trigger_pulse_n,
  // Arbitration
  output logic             busRequestN,
  input  wire logic        busGrantN,
  input  wire logic        busyIn,
  output logic             busyOut,
  output logic             busyOe,
  input  wire logic        lockIn,
  output logic             lockOut,
  output logic             lockOe,
  // Bus side
  input  wire logic [15:0] infoIn,
  output logic      [15:0] info_bus,
  output logic             infoOe,
  output logic             addr_strobe,
  output logic             data_strobe_n,
  output logic             dataInstr,
  output logic             readWrite,
  output logic             memIo,
  input  wire logic        memIoIn,
  output logic             busCtlOe,
  input  wire logic        rdyA,
  input  wire logic        rdyD,
  input  wire logic        protect_fault_n,
  input  wire logic        ext_address_fault_n
);

  bad_pkg::bad_state_t state_q;
  bad_pkg::bad_state_t state_d;
  logic        lockHold_q;
  logic        ownCycle;
  logic        startCycle;
  logic        apbWr;
  logic [15:0] faultReg;
  logic [15:0] faultClr;
  logic [3:0]  trigCnt_q;
  logic        initPend_q;
  logic        trigFire;
  logic        cmdTrig;

  function automatic logic isLockOp(input logic [3:0] op);
    case (bad_pkg::bad_op_t'(op))
      bad_pkg::op_increment_memory,
      bad_pkg::op_decrement_memory,
      bad_pkg::op_set_bit,
      bad_pkg::op_reset_bit,
      bad_pkg::op_test_set_bit,
      bad_pkg::op_store_masked,
      bad_pkg::op_store_upper_byte,
      bad_pkg::op_store_lower_byte: isLockOp = 1'b1;
      default:                      isLockOp = 1'b0;
    endcase
  endfunction

  function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
    hitReg = (a == off);
  endfunction

  // Bus free means no foreign busy and no foreign lock, unless the lock is ours
  assign startCycle = (state_q == bad_pkg::ST_REQ) && !busGrantN &&
                      busyIn && (lockIn || lockHold_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      bad_pkg::ST_IDLE: begin
        if (cycReq) begin
          state_d = bad_pkg::ST_REQ;
        end
      end
      bad_pkg::ST_REQ: begin
        if (startCycle) begin
          state_d = bad_pkg::ST_ADDR;
        end
      end
      bad_pkg::ST_ADDR: begin
        if (rdyA) begin
          state_d = bad_pkg::ST_DATA;
        end
      end
      bad_pkg::ST_DATA: begin
        if (rdyD) begin
          state_d = bad_pkg::ST_END;
        end
      end
      bad_pkg::ST_END:  state_d = bad_pkg::ST_IDLE;
      default:          state_d = bad_pkg::ST_IDLE;
    endcase
  end

  // A lost grant never aborts ADDR/DATA/END; only REQ waits on it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= bad_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign ownCycle = (state_q == bad_pkg::ST_ADDR) || (state_q == bad_pkg::ST_DATA) ||
                    (state_q == bad_pkg::ST_END);

  assign busRequestN = (state_q != bad_pkg::ST_REQ);
  assign busyOe      = ownCycle;
  assign busyOut     = (state_q == bad_pkg::ST_END);
  assign lockOe      = ownCycle || lockHold_q;
  assign lockOut     = busyOut && !lockHold_q;
  assign busCtlOe    = ownCycle;
  assign cycAck      = (state_q == bad_pkg::ST_END);

  // Lock spans from the first cycle of a locked instruction to its last
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockHold_q <= 1'b0;
    end else if (startCycle && isLockOp(cycOp) && !cycLast) begin
      lockHold_q <= 1'b1;
    end else if ((state_q == bad_pkg::ST_END) && cycLast) begin
      lockHold_q <= 1'b0;
    end
  end

  // Bus-side outputs registered; enables follow ownership
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      info_bus      <= 16'h0000;
      infoOe        <= 1'b0;
      addr_strobe   <= 1'b0;
      data_strobe_n <= 1'b1;
      dataInstr     <= 1'b0;
      readWrite     <= 1'b1;
      memIo         <= 1'b1;
    end else begin
      addr_strobe   <= (state_d == bad_pkg::ST_ADDR);
      data_strobe_n <= !(state_d == bad_pkg::ST_DATA);
      infoOe        <= (state_d == bad_pkg::ST_ADDR) ||
                       ((state_d == bad_pkg::ST_DATA) && cycWrite);
      if (startCycle) begin
        info_bus  <= cycAddr;
        dataInstr <= cycData;
        readWrite <= !cycWrite;
        memIo     <= cycMem;
      end else if ((state_q == bad_pkg::ST_ADDR) && rdyA) begin
        info_bus  <= cycWdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycRdata <= 16'h0000;
    end else if ((state_q == bad_pkg::ST_DATA) && rdyD && !cycWrite) begin
      cycRdata <= infoIn;
    end
  end

  // APB: zero wait state, errors on unmapped offsets
  assign pready  = 1'b1;
  assign apbWr   = psel && penable && pwrite;
  assign pslverr = psel && penable && !hitReg(paddr, bad_pkg::REG_CMD_STATUS) &&
                   !hitReg(paddr, bad_pkg::REG_FAULT);
  assign cmdTrig = apbWr && hitReg(paddr, bad_pkg::REG_CMD_STATUS) &&
                   pwdata[bad_pkg::CMD_TRIGGER];
  assign faultClr = (apbWr && hitReg(paddr, bad_pkg::REG_FAULT)) ? pwdata[15:0] : 16'h0000;

  always_comb begin
    prdata = 32'h0000_0000;
    if (hitReg(paddr, bad_pkg::REG_CMD_STATUS)) begin
      prdata[bad_pkg::STS_DA]   = directAccessEn;
      prdata[bad_pkg::STS_PASS] = selftest_pass;
      prdata[bad_pkg::STS_LOCK] = lockHold_q;
      prdata[bad_pkg::STS_STATE_LSB +: 3] = state_q;
    end else if (hitReg(paddr, bad_pkg::REG_FAULT)) begin
      prdata[15:0] = faultReg;
    end
  end

  // Off command wins if both bits are written together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      directAccessEn <= 1'b0;
    end else if (apbWr && hitReg(paddr, bad_pkg::REG_CMD_STATUS)) begin
      if (pwdata[bad_pkg::CMD_DA_OFF]) begin
        directAccessEn <= 1'b0;
      end else if (pwdata[bad_pkg::CMD_DA_ON]) begin
        directAccessEn <= 1'b1;
      end
    end
  end

  // Self-test success wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selftest_pass <= 1'b0;
    end else if (selftestOk) begin
      selftest_pass <= 1'b1;
    end else if (apbWr && hitReg(paddr, bad_pkg::REG_CMD_STATUS) &&
                 pwdata[bad_pkg::CMD_CLR_PASS]) begin
      selftest_pass <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_begin <= 1'b0;
    end else begin
      instr_begin <= instrNext;
    end
  end

  // Requests arriving while a pulse runs merge into it
  assign trigFire = (startCycle && !cycMem && (cycAddr == bad_pkg::TRIG_IO_ADDR)) ||
                    cmdTrig || initPend_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigCnt_q  <= 4'h0;
      initPend_q <= 1'b1;
    end else begin
      if (trigFire && (trigCnt_q == 4'h0)) begin
        trigCnt_q <= bad_pkg::TRIG_CNT_LOAD;
      end else if (trigCnt_q != 4'h0) begin
        trigCnt_q <= trigCnt_q - 4'h1;
      end
      if (trigCnt_q == 4'h0) begin
        initPend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigger_pulse_n <= 1'b1;
    end else begin
      trigger_pulse_n <= !((trigFire && (trigCnt_q == 4'h0)) || (trigCnt_q > 4'h1));
    end
  end

  bad_fault_capture u_fault (
    .clk                 (clk),
    .rst_n               (rst_n),
    .busyIn              (busyIn),
    .busyOwn             (busyOe),
    .memIoIn             (memIoIn),
    .protect_fault_n     (protect_fault_n),
    .ext_address_fault_n (ext_address_fault_n),
    .clearMask           (faultClr),
    .faultReg            (faultReg)
  );

  property p_req_low;
    @(posedge clk) disable iff (!rst_n)
      (state_q == bad_pkg::ST_IDLE) && cycReq |=> !busRequestN;
  endproperty
  a_req_low: assert property (p_req_low) else $error("bus request not asserted");

  property p_req_release;
    @(posedge clk) disable iff (!rst_n)
      startCycle |=> busRequestN && !busyOut && busyOe;
  endproperty
  a_req_release: assert property (p_req_release) else $error("request held after start");

  property p_no_grant_no_start;
    @(posedge clk) disable iff (!rst_n)
      (state_q == bad_pkg::ST_REQ) && (busGrantN || !busyIn) |=> (state_q == bad_pkg::ST_REQ);
  endproperty
  a_no_grant_no_start: assert property (p_no_grant_no_start) else $error("cycle began unowned");

  property p_hiz_idle;
    @(posedge clk) disable iff (!rst_n)
      busGrantN && !ownCycle |-> !busCtlOe && !infoOe && !busyOe;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle) else $error("bus driven without grant");

  property p_busy_frame;
    @(posedge clk) disable iff (!rst_n)
      $rose(busyOe) |-> !busyOut ##1 !busyOut;
  endproperty
  a_busy_frame: assert property (p_busy_frame) else $error("busy not low at cycle start");

  property p_busy_end;
    @(posedge clk) disable iff (!rst_n)
      $rose(busyOut) |=> !busyOe && (state_q == bad_pkg::ST_IDLE);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not released after end");

  property p_lock_mimic;
    @(posedge clk) disable iff (!rst_n)
      busyOe && !lockHold_q |-> lockOe && (lockOut == busyOut);
  endproperty
  a_lock_mimic: assert property (p_lock_mimic) else $error("lock does not follow busy");

  property p_lock_hold;
    @(posedge clk) disable iff (!rst_n)
      startCycle && isLockOp(cycOp) && !cycLast |=> lockOe && !lockOut;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked instruction left bus open");

  property p_da_off;
    @(posedge clk) disable iff (!rst_n)
      apbWr && (paddr == bad_pkg::REG_CMD_STATUS) && pwdata[1] |=> !directAccessEn;
  endproperty
  a_da_off: assert property (p_da_off) else $error("direct access not cleared");

  property p_trig_width;
    @(posedge clk) disable iff (!rst_n)
      $fell(trigger_pulse_n) |-> !trigger_pulse_n [*2] ##1 trigger_pulse_n;
  endproperty
  a_trig_width: assert property (p_trig_width) else $error("trigger pulse width wrong");

endmodule
`default_nettype wire

// ### tb/bad_arbiter_model.sv
// Arbiter and other-master model with pulled-up busy and lock lines
`timescale 1ns/1ns
`default_nettype none
module bad_arbiter_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       busRequestN,
  input  wire logic       busyOut,
  input  wire logic       busyOe,
  input  wire logic       lockOut,
  input  wire logic       lockOe,
  input  wire logic [3:0] grantDelay,
  input  wire logic       extBusyN,
  input  wire logic       extLockN,
  output logic            busGrantN,
  output logic            busyWire,
  output logic            lockWire
);
  logic [3:0] waitCnt_q;
  // Undriven lines float to the pull-up level
  assign busyWire = busyOe ? busyOut : extBusyN;
  assign lockWire = lockOe ? lockOut : extLockN;
  always_ff @(posedge clk) begin
    if (!rst_n || busRequestN)
      waitCnt_q <= 4'h0;
    else if (waitCnt_q != 4'hf)
      waitCnt_q <= waitCnt_q + 4'h1;
  end
  // Slow or prompt grant; never taken away while this master drives busy or the lock line is low
  always_ff @(posedge clk) begin
    if (!rst_n)
      busGrantN <= 1'b1;
    else if (!busRequestN && waitCnt_q >= grantDelay)
      busGrantN <= 1'b0;
    else if (busRequestN && !busyOe && lockWire)
      busGrantN <= 1'b1;
  end
endmodule
`default_nettype wire

// ### tb/bus_arbitration_discretes_test.sv
// Self-checking bench for the bus arbitration and discrete block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin cmpCount++; if ((a) !== (b)) begin \
  badCount++; $display("BAD %0t %s", $time, m); end end
module bus_arbitration_discretes_test;
  logic        clk, rst_n, psel, penable, pwrite, cycReq, cycWrite, cycMem;
  logic        cycLast, instrNext, selftestOk, rdyA, rdyD, extBusyN, extMemIo;
  logic        protect_fault_n, ext_address_fault_n, busGrantN, busyWire, lockWire;
  logic        pready, pslverr, cycAck, selftest_pass, instr_begin, directAccessEn;
  logic        trigger_pulse_n, busRequestN, busyOut, busyOe, lockOut, lockOe;
  logic        infoOe, addr_strobe, data_strobe_n, dataInstr, readWrite, memIo, busCtlOe;
  logic        slv, locked;
  logic [3:0]  cycOp, grantDelay;
  logic [7:0]  paddr;
  logic [15:0] cycAddr, cycWdata, info_bus, cycRdata;
  logic [31:0] pwdata, prdata, rd;
  int          badCount, cmpCount, cycles, trigLows, lockHold;

  bad_top u_dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cycReq, .cycWrite, .cycMem, .cycData(1'b1), .cycAddr, .cycWdata, .cycOp, .cycLast,
    .cycAck, .cycRdata, .instrNext, .selftestOk, .selftest_pass, .instr_begin,
    .directAccessEn, .trigger_pulse_n, .busRequestN, .busGrantN, .busyIn(busyWire),
    .busyOut, .busyOe, .lockIn(lockWire), .lockOut, .lockOe, .infoIn(cycAddr ^ 16'h5a5a),
    .info_bus, .infoOe, .addr_strobe, .data_strobe_n, .dataInstr, .readWrite, .memIo,
    .memIoIn(busCtlOe ? memIo : extMemIo), .busCtlOe, .rdyA, .rdyD, .protect_fault_n,
    .ext_address_fault_n);
  bad_arbiter_model u_arb (
    .clk, .rst_n, .busRequestN, .busyOut, .busyOe, .lockOut, .lockOe, .grantDelay,
    .extBusyN, .extLockN(lockHold == 0), .busGrantN, .busyWire, .lockWire);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) if (trigger_pulse_n === 1'b0) trigLows++;
  always @(posedge clk) if (lockHold != 0) lockHold <= lockHold - 1;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // One bus cycle from request to acknowledge, judging the wire on the way
  task automatic cyc(input logic w, m, input logic [15:0] a, input logic [3:0] op,
                     input logic last);
    logic sawReq, sawLow;
    sawReq = 1'b0;
    sawLow = 1'b0;
    cycReq <= 1'b1;
    cycWrite <= w;
    cycMem <= m;
    cycAddr <= a;
    cycWdata <= ~a;
    cycOp <= op;
    cycLast <= last;
    do begin
      @(negedge clk);
      if (busRequestN === 1'b0) sawReq = 1'b1;
      if (lockWire === 1'b0 && lockOe !== 1'b1) `CHK(busyOe, 1'b0, "start under lock")
      if (busyOe === 1'b1) begin
        `CHK(busRequestN, 1'b1, "request kept")
        if (busyOut === 1'b0 && !sawLow)
          `CHK({addr_strobe, infoOe, info_bus, readWrite, memIo}, {2'b11, a, !w, m}, "addr")
        if (data_strobe_n === 1'b0) `CHK({infoOe, addr_strobe}, {w, 1'b0}, "data phase")
        if (data_strobe_n === 1'b0 && w) `CHK(info_bus, ~a, "write data")
        if (busyOut === 1'b0) sawLow = 1'b1;
        if (busyOut === 1'b0 || !locked) `CHK({lockOe, lockOut}, {1'b1, busyOut}, "lock")
      end else if (busGrantN === 1'b1)
        `CHK({busCtlOe, infoOe}, 2'b00, "driven w/o grant")
    end while (cycAck !== 1'b1);
    `CHK({sawReq, sawLow, busyOut, data_strobe_n, dataInstr}, 5'b11111, "frame")
    if (!w) `CHK(cycRdata, a ^ 16'h5a5a, "read data")
    @(posedge clk) cycReq <= 1'b0;
    @(posedge clk);
  endtask

  task automatic resetCheck();
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(trigLows, bad_pkg::TRIG_CYCLES, "init pulse")
    `CHK({directAccessEn, selftest_pass, busRequestN, busyOe}, 4'b0010, "reset")
  endtask

  task automatic plainCycles();
    grantDelay <= 4'h3;
    cyc(1'b0, 1'b1, 16'h0123, 4'h0, 1'b1);
    grantDelay <= 4'h0;
    cyc(1'b1, 1'b1, 16'h4567, 4'h0, 1'b1);
    lockHold <= 8;
    cyc(1'b0, 1'b1, 16'h0010, 4'h0, 1'b1);
  endtask

  task automatic triggerIo();
    trigLows = 0;
    cyc(1'b1, 1'b1, 16'h400b, 4'h0, 1'b1);
    cyc(1'b1, 1'b0, 16'h400a, 4'h0, 1'b1);
    cyc(1'b0, 1'b0, 16'h400b, 4'h0, 1'b1);
    repeat (4) @(posedge clk);
    `CHK(trigLows, bad_pkg::TRIG_CYCLES, "io trigger")
  endtask

  task automatic lockedOps();
    for (int op = 1; op <= 8; op++) begin
      locked = 1'b1;
      cyc(1'b0, 1'b1, 16'h0200, 4'(op), 1'b0);
      @(negedge clk) `CHK({lockOe, lockOut}, 2'b10, "lock between")
      @(posedge clk);
      cyc(1'b1, 1'b1, 16'h0200, 4'(op), 1'b1);
      locked = 1'b0;
      @(negedge clk) `CHK(lockOe, 1'b0, "lock released")
      @(posedge clk);
    end
  endtask

  task automatic faults();
    extMemIo <= 1'b0;
    extBusyN <= 1'b0;
    protect_fault_n <= 1'b0;
    ext_address_fault_n <= 1'b0;
    repeat (3) @(negedge clk) `CHK({busyOe, lockOe}, 2'b00, "foreign cycle driven")
    @(posedge clk) extBusyN <= 1'b1;
    @(posedge clk) protect_fault_n <= 1'b1;
    ext_address_fault_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[15:0], 16'h0102, "foreign faults")
    apb(1'b1, 8'h04, 32'h0000ffff);
    protect_fault_n <= 1'b0;
    ext_address_fault_n <= 1'b0;
    cyc(1'b0, 1'b1, 16'h0040, 4'h0, 1'b1);
    protect_fault_n <= 1'b1;
    ext_address_fault_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[15:0], 16'h0021, "own faults")
  endtask

  task automatic discretes();
    apb(1'b1, 8'h00, 32'h1);
    `CHK(directAccessEn, 1'b1, "da on")
    apb(1'b0, 8'h00, 32'h0);
    `CHK({slv, rd}, {1'b0, 32'h1}, "status read")
    apb(1'b1, 8'h00, 32'h3);
    `CHK(directAccessEn, 1'b0, "da off")
    selftestOk <= 1'b1;
    @(posedge clk) selftestOk <= 1'b0;
    @(negedge clk) `CHK(selftest_pass, 1'b1, "pass set")
    @(posedge clk) apb(1'b1, 8'h00, 32'h4);
    `CHK(selftest_pass, 1'b0, "pass clear")
    instrNext <= 1'b1;
    @(posedge clk) instrNext <= 1'b0;
    @(negedge clk) `CHK(instr_begin, 1'b1, "start high")
    @(negedge clk) `CHK(instr_begin, 1'b0, "start low")
    @(posedge clk) trigLows = 0;
    apb(1'b1, 8'h00, 32'h8);
    repeat (3) @(posedge clk);
    `CHK(trigLows, bad_pkg::TRIG_CYCLES, "cmd trigger")
    apb(1'b0, 8'h08, 32'h0);
    `CHK({slv, rd}, {1'b1, 32'h0}, "unmapped")
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, cycReq, cycWrite, cycMem, cycLast} = '0;
    {instrNext, selftestOk, extMemIo, locked} = '0;
    {rdyA, rdyD, extBusyN, protect_fault_n, ext_address_fault_n} = '1;
    {cycOp, grantDelay, paddr, cycAddr, cycWdata, pwdata} = '0;
    {badCount, cmpCount, cycles, trigLows, lockHold} = '0;
    resetCheck();
    plainCycles();
    triggerIo();
    lockedOps();
    faults();
    discretes();
    giveVerdict();
  end
endmodule
`default_nettype wire
